//--- design/serdes_bypass_cfg.svh
// Offsets, field positions, reset values and counts of the bypass serializer
`ifndef SERDES_BYPASS_CFG_SVH
`define SERDES_BYPASS_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_CTRL         8'h00
`define REG_RATE         8'h04
`define REG_STATUS       8'h08

// ----------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------
`define CTRL_EN_BIT      0
`define CTRL_MODE_POS    1
`define CTRL_INREG_BIT   3
`define CTRL_INCORE_BIT  4
`define CTRL_INALN_POS   5
`define CTRL_OUTALN_POS  8

// ----------------------------------------------------------------
// Status field positions
// ----------------------------------------------------------------
`define ST_TXWR_BIT      0
`define ST_TXRD_BIT      1
`define ST_RXWR_BIT      2
`define ST_RXRD_BIT      3
`define ST_RATEERR_BIT   4
`define ST_DDRREC_BIT    5
`define ST_CLKERR_BIT    6
`define ST_OUTPH_POS     8
`define ST_INPH_POS      12
`define ST_FAST_POS      16
`define ST_SLOW_POS      24

// ----------------------------------------------------------------
// Reset values, limits and counts
// ----------------------------------------------------------------
`define FAST_START       0
`define SLOW_START       3'd2
`define RATE_RESET       10'h000
`define BYPASS_MAX_MBPS  10'd624
`define X1_DDR_MBPS      10'd231
`define X1_CLK_MAX_MHZ   10'd420
`define TX_WR_INVALID    3'd2
`define RX_RD_INVALID    3'd6
`define RX_WR_MULT       3
`define TX_RD_MULT       1
`define PHASE_CENTER     3'd4

`endif

//--- design/serdes_bypass_pkg.sv
// Types shared by the bypass serializer
package serdes_bypass_pkg;

    typedef logic [2:0] phase_t;

    typedef enum logic [1:0] {
        MODE_X1   = 2'b00,
        MODE_X2   = 2'b01,
        MODE_GEAR = 2'b10
    } mode_t;

    typedef enum logic [2:0] {
        AL_EDGE   = 3'b000,
        AL_CENTER = 3'b001,
        AL_45     = 3'b010,
        AL_135    = 3'b011,
        AL_180    = 3'b100,
        AL_225    = 3'b101,
        AL_270    = 3'b110,
        AL_315    = 3'b111
    } align_t;

endpackage : serdes_bypass_pkg

//--- design/serdes_bypass.sv
// Bypass serializer: DDR output path, RAM gearbox and APB control
//
// What this block does
// - Input and output data-to-clock alignment each selectable; edge default.
// - Center alignment gives the same phase as 180 degrees.
// - Optional input register clocked by reference or core enable.
// - Bypass only below 624 Mbps; x1 and x2 always bypass.
// - Forwarded clock from DDR register, high slot one, low slot zero.
// - Forwarded clock rate equals the DDR register clock rate.
// - x1: DDR recommended above 231 Mbps; clock at most 420 MHz.
// - x2: data passes through DDR registers; below 624 Mbps.
// - Two counters per memory; fast starts at 0, slow at 2.
// - Gearbox memory is simple dual-port; transmit write and receive read only on core enable.
// - Transmit: read address fast counter, write address slow counter.
// - Receive: write address fast counter, read address slow counter.
// - Receive writes invalid first 3xfactor cycles, reads first 6.
// - Transmit writes invalid first 2 cycles, reads first factor cycles.
// - Address bits above a counter's width are tied to zero.
// - Core rate is fast rate times two over the factor.
// - Parallel width equals channels times factor.
`timescale 1ns/1ps
`include "serdes_bypass_cfg.svh"

module serdes_bypass #(
    parameter int CHANNELS = 1,
    parameter int FACTOR   = 4,
    parameter int MEM_AW   = 8
) (
    // Clock and reset
    input  wire logic                         sys_clk_in,
    input  wire logic                         srst_in,
    // APB slave
    input  wire logic                         psel_in,
    input  wire logic                         penable_in,
    input  wire logic                         pwrite_in,
    input  wire logic [7:0]                   paddr_in,
    input  wire logic [31:0]                  pwdata_in,
    output logic      [31:0]                  prdata_out,
    output logic                              pready_out,
    output logic                              pslverr_out,
    // Parallel side
    input  wire logic                         inclk_en_in,
    input  wire logic [CHANNELS*FACTOR-1:0]   tx_data_in,
    output logic      [CHANNELS*FACTOR-1:0]   rx_data_out,
    output logic                              rx_valid_out,
    output logic                              core_en_out,
    // DDR register slots toward the pins
    output logic      [CHANNELS-1:0]          tx_hi_out,
    output logic      [CHANNELS-1:0]          tx_lo_out,
    output logic                              tx_valid_out,
    output logic                              clk_hi_out,
    output logic                              clk_lo_out,
    input  wire logic [CHANNELS-1:0]          rx_hi_in,
    input  wire logic [CHANNELS-1:0]          rx_lo_in,
    // Phase requests for the clock generator
    output serdes_bypass_pkg::phase_t         in_phase_out,
    output serdes_bypass_pkg::phase_t         out_phase_out
);
    import serdes_bypass_pkg::*;

    // ------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------
    localparam int DW     = CHANNELS * FACTOR;
    localparam int NW     = 8;
    localparam int FAST_W = $clog2(4 * FACTOR);
    localparam int PB     = FAST_W - 3;
    localparam int SAT_F  = `RX_WR_MULT * FACTOR;

    typedef struct packed {
        logic                      enable;
        mode_t                     mode;
        logic                      in_reg_en;
        logic                      in_core;
        align_t                    in_align;
        align_t                    out_align;
        logic [9:0]                rate;
        logic [FAST_W-1:0]         fast_cnt;
        logic [2:0]                slow_cnt;
        logic [6:0]                fast_seen;
        logic [2:0]                slow_seen;
        logic [NW-1:0][DW-1:0]     tx_mem;
        logic [NW-1:0][DW-1:0]     rx_mem;
        logic [DW-1:0]             in_reg;
        logic [DW-1:0]             rx_word;
        logic [CHANNELS-1:0]       tx_hi;
        logic [CHANNELS-1:0]       tx_lo;
        logic [CHANNELS-1:0]       last_lo;
        logic                      clk_hi;
        logic                      clk_lo;
        logic                      core_en;
        logic                      tx_wr_v;
        logic                      tx_rd_v;
        logic                      rx_wr_v;
        logic                      rx_rd_v;
        logic                      rate_err;
        logic                      ddr_rec;
        logic                      clk_err;
        phase_t                    in_phase;
        phase_t                    out_phase;
        logic [31:0]               prdata;
        logic                      pready;
        logic                      pslverr;
    } state_t;

    state_t s;
    state_t n;

    // ------------------------------------------------------------
    // Alignment to phase in eighths of a bit period
    // ------------------------------------------------------------
    function automatic phase_t eff_phase(input align_t a);
        phase_t p;
        p = 3'd0;
        unique case (a)
            AL_EDGE:   p = 3'd0;
            AL_CENTER: p = `PHASE_CENTER;
            AL_45:     p = 3'd1;
            AL_135:    p = 3'd3;
            AL_180:    p = 3'd4;
            AL_225:    p = 3'd5;
            AL_270:    p = 3'd6;
            AL_315:    p = 3'd7;
        endcase
        return p;
    endfunction : eff_phase

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [DW-1:0]       src;
    logic                slow_en;
    logic                wr_acc;
    logic [MEM_AW-1:0]   tx_wr_addr;
    logic [MEM_AW-1:0]   tx_rd_addr;
    logic [31:0]         rd;

    always_comb begin
        int base;
        int hb;
        logic [CHANNELS-1:0] cur_hi;
        logic [CHANNELS-1:0] cur_lo;
        base   = 0;
        hb     = 0;
        cur_hi = '0;
        cur_lo = '0;
        n      = s;

        // Core enable once per word of fast cycles
        slow_en = s.enable && (&s.fast_cnt[PB-1:0]);
        // Counters narrower than the port; upper bits held low
        tx_wr_addr = MEM_AW'(s.slow_cnt);
        tx_rd_addr = MEM_AW'(s.fast_cnt);

        // Input register boundary
        if (s.in_reg_en && (s.in_core ? slow_en : inclk_en_in)) begin
            n.in_reg = tx_data_in;
        end
        src = s.in_reg_en ? s.in_reg : tx_data_in;

        // Gearbox counters; idle holds them at their start values
        if (s.enable) begin
            n.fast_cnt = s.fast_cnt + 1'b1;
            if (slow_en) begin
                n.slow_cnt = s.slow_cnt + 1'b1;
            end
            if (s.fast_seen != 7'(SAT_F)) begin
                n.fast_seen = s.fast_seen + 7'd1;
            end
            if (slow_en && (s.slow_seen != `RX_RD_INVALID)) begin
                n.slow_seen = s.slow_seen + 3'd1;
            end
        end else begin
            n.fast_cnt  = FAST_W'(`FAST_START);
            n.slow_cnt  = `SLOW_START;
            n.fast_seen = 7'd0;
            n.slow_seen = 3'd0;
        end
        n.core_en = slow_en;

        // Transmit write on every core cycle at the slow address
        if (slow_en) begin
            n.tx_mem[tx_wr_addr[2:0]] = src;
        end

        // Per-channel serial slots
        for (int c = 0; c < CHANNELS; c++) begin
            base = c * FACTOR;
            hb   = base + FACTOR - 1 - 2 * int'(s.fast_cnt[PB-1:0]);
            unique case (s.mode)
                MODE_X1: begin
                    cur_hi[c] = src[base];
                    cur_lo[c] = src[base];
                end
                MODE_X2: begin
                    cur_hi[c] = src[base + 1];
                    cur_lo[c] = src[base];
                end
                MODE_GEAR: begin
                    cur_hi[c] = s.tx_mem[tx_rd_addr[FAST_W-1 -: 3]][hb];
                    cur_lo[c] = s.tx_mem[tx_rd_addr[FAST_W-1 -: 3]][hb - 1];
                end
                default: begin
                    cur_hi[c] = 1'b0;
                    cur_lo[c] = 1'b0;
                end
            endcase
            // Receive write of one pair at the fast address
            if (s.enable) begin
                n.rx_mem[s.fast_cnt[FAST_W-1 -: 3]][hb]     = rx_hi_in[c];
                n.rx_mem[s.fast_cnt[FAST_W-1 -: 3]][hb - 1] = rx_lo_in[c];
            end
        end

        // Late half of the bit shifts data by one DDR slot
        if (s.out_phase >= `PHASE_CENTER) begin
            n.tx_hi = s.last_lo;
            n.tx_lo = cur_hi;
        end else begin
            n.tx_hi = cur_hi;
            n.tx_lo = cur_lo;
        end
        n.last_lo = cur_lo;
        if (!s.enable) begin
            n.tx_hi = '0;
            n.tx_lo = '0;
        end

        // Receive read of a whole word at the slow address
        if (slow_en) begin
            n.rx_word = s.rx_mem[s.slow_cnt];
        end

        // Forwarded clock runs at the fast rate
        n.clk_hi = 1'b1;
        n.clk_lo = 1'b0;

        // Start-up windows of the gearbox
        n.tx_wr_v = s.slow_seen >= `TX_WR_INVALID;
        n.tx_rd_v = s.fast_seen >= 7'(`TX_RD_MULT * FACTOR);
        n.rx_wr_v = s.fast_seen >= 7'(SAT_F);
        n.rx_rd_v = s.slow_seen >= `RX_RD_INVALID;

        // Rate checks
        n.rate_err = s.rate >= `BYPASS_MAX_MBPS;
        n.ddr_rec  = (s.mode == MODE_X1) && (s.rate > `X1_DDR_MBPS);
        n.clk_err  = (s.mode == MODE_X1) && (s.rate > `X1_CLK_MAX_MHZ);

        n.in_phase  = eff_phase(s.in_align);
        n.out_phase = eff_phase(s.out_align);

        // APB: answer prepared in setup, pready high in access
        wr_acc = psel_in && penable_in && s.pready && pwrite_in;
        rd     = 32'h0000_0000;
        unique case (paddr_in)
            `REG_CTRL: begin
                rd[`CTRL_EN_BIT]              = s.enable;
                rd[`CTRL_MODE_POS +: 2]       = s.mode;
                rd[`CTRL_INREG_BIT]           = s.in_reg_en;
                rd[`CTRL_INCORE_BIT]          = s.in_core;
                rd[`CTRL_INALN_POS +: 3]      = s.in_align;
                rd[`CTRL_OUTALN_POS +: 3]     = s.out_align;
            end
            `REG_RATE: begin
                rd[9:0] = s.rate;
            end
            `REG_STATUS: begin
                rd[`ST_TXWR_BIT]    = s.tx_wr_v;
                rd[`ST_TXRD_BIT]    = s.tx_rd_v;
                rd[`ST_RXWR_BIT]    = s.rx_wr_v;
                rd[`ST_RXRD_BIT]    = s.rx_rd_v;
                rd[`ST_RATEERR_BIT] = s.rate_err;
                rd[`ST_DDRREC_BIT]  = s.ddr_rec;
                rd[`ST_CLKERR_BIT]  = s.clk_err;
                rd[`ST_OUTPH_POS +: 3] = s.out_phase;
                rd[`ST_INPH_POS +: 3]  = s.in_phase;
                rd[`ST_FAST_POS +: 8]  = tx_rd_addr[7:0];
                rd[`ST_SLOW_POS +: 3]  = s.slow_cnt;
            end
            default: begin
                rd = 32'h0000_0000;
            end
        endcase
        n.pready = psel_in && !penable_in && !s.pready;
        if (psel_in && !penable_in) begin
            n.prdata  = rd;
            n.pslverr = !((paddr_in == `REG_CTRL) || (paddr_in == `REG_RATE)
                          || (paddr_in == `REG_STATUS));
        end
        if (wr_acc && (paddr_in == `REG_CTRL)) begin
            n.enable    = pwdata_in[`CTRL_EN_BIT];
            n.mode      = mode_t'(pwdata_in[`CTRL_MODE_POS +: 2]);
            n.in_reg_en = pwdata_in[`CTRL_INREG_BIT];
            n.in_core   = pwdata_in[`CTRL_INCORE_BIT];
            n.in_align  = align_t'(pwdata_in[`CTRL_INALN_POS +: 3]);
            n.out_align = align_t'(pwdata_in[`CTRL_OUTALN_POS +: 3]);
        end
        if (wr_acc && (paddr_in == `REG_RATE)) begin
            n.rate = pwdata_in[9:0];
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            s          <= '0;
            s.mode     <= MODE_GEAR;
            s.rate     <= `RATE_RESET;
            s.fast_cnt <= FAST_W'(`FAST_START);
            s.slow_cnt <= `SLOW_START;
            s.clk_hi   <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign prdata_out    = s.prdata;
    assign pready_out    = s.pready;
    assign pslverr_out   = s.pslverr;
    assign rx_data_out   = s.rx_word;
    assign rx_valid_out  = s.rx_rd_v && s.rx_wr_v;
    assign core_en_out   = s.core_en;
    assign tx_hi_out     = s.tx_hi;
    assign tx_lo_out     = s.tx_lo;
    assign tx_valid_out  = s.tx_rd_v && s.tx_wr_v;
    assign clk_hi_out    = s.clk_hi;
    assign clk_lo_out    = s.clk_lo;
    assign in_phase_out  = s.in_phase;
    assign out_phase_out = s.out_phase;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_counter_start: assert property (@(posedge sys_clk_in)
        $fell(srst_in) |-> (s.slow_cnt == 3'd2) && (s.fast_cnt == '0))
        else $error("counters not at start values after reset");

    a_fast_step: assert property (@(posedge sys_clk_in)
        disable iff (srst_in)
        s.enable && $past(s.enable) && !$past(srst_in)
        |-> s.fast_cnt == FAST_W'($past(s.fast_cnt) + 1'b1))
        else $error("fast counter did not step by one");

    a_slow_lead: assert property (@(posedge sys_clk_in)
        disable iff (srst_in)
        s.slow_cnt - s.fast_cnt[FAST_W-1 -: 3] == 3'd2)
        else $error("slow address not two words ahead");

    a_clock_slots: assert property (@(posedge sys_clk_in)
        disable iff (srst_in)
        ##1 clk_hi_out && !clk_lo_out)
        else $error("forwarded clock slots wrong");

    a_center_phase: assert property (@(posedge sys_clk_in)
        disable iff (srst_in)
        s.out_align == AL_CENTER |=> out_phase_out == 3'd4)
        else $error("center alignment differs from 180 degrees");

    a_rate_limit: assert property (@(posedge sys_clk_in)
        disable iff (srst_in)
        s.rate >= 10'd624 |=> s.rate_err)
        else $error("rate at or above 624 not flagged");

    a_x1_clock: assert property (@(posedge sys_clk_in)
        disable iff (srst_in)
        (s.mode == MODE_X1) && (s.rate > 10'd420) |=> s.clk_err)
        else $error("x1 clock above 420 not flagged");

    a_tx_invalid: assert property (@(posedge sys_clk_in)
        disable iff (srst_in)
        s.fast_seen < 7'(FACTOR) |=> !tx_valid_out)
        else $error("transmit valid during invalid start-up reads");

    a_rx_invalid: assert property (@(posedge sys_clk_in)
        disable iff (srst_in)
        (s.slow_seen < 3'd6) || (s.fast_seen < 7'(SAT_F))
        |=> !rx_valid_out)
        else $error("receive valid during invalid start-up cycles");

    a_x2_pair: assert property (@(posedge sys_clk_in)
        disable iff (srst_in)
        s.enable && (s.mode == MODE_X2) && (s.out_phase < 3'd4)
        |=> tx_hi_out[0] == $past(src[1]) && tx_lo_out[0] == $past(src[0]))
        else $error("x2 pair not passed to DDR slots");

endmodule : serdes_bypass

//--- tb/lvds_remote_rx.sv
// Remote LVDS receiver model that loops the serial slots back
`timescale 1ns/1ps

module lvds_remote_rx #(
    parameter int CHANNELS = 1
) (
    // Clock and reset
    input  wire logic                sys_clk_in,
    input  wire logic                srst_in,
    // Link from the block
    input  wire logic [CHANNELS-1:0] tx_hi_in,
    input  wire logic [CHANNELS-1:0] tx_lo_in,
    input  wire logic                tx_valid_in,
    input  wire logic                clk_hi_in,
    input  wire logic                clk_lo_in,
    // Link back to the block
    output logic      [CHANNELS-1:0] rx_hi_out,
    output logic      [CHANNELS-1:0] rx_lo_out,
    output logic                     clk_bad_out
);
    initial begin
        rx_hi_out   = '0;
        rx_lo_out   = '0;
        clk_bad_out = 1'b0;
    end

    always @(posedge sys_clk_in) begin
        // Forwarded clock slots: high one, low zero, every cycle
        if (!srst_in && (clk_hi_in !== 1'b1 || clk_lo_in !== 1'b0)) begin
            clk_bad_out <= 1'b1;
        end
        if (tx_valid_in === 1'b1) begin
            rx_hi_out <= tx_hi_in;
            rx_lo_out <= tx_lo_in;
        end else begin
            // No valid frame: never hold a stale level
            rx_hi_out <= ~rx_hi_out;
            rx_lo_out <= ~rx_lo_out;
        end
    end
endmodule : lvds_remote_rx

//--- tb/serdes_bypass_test.sv
// Self-checking bench for the bypass serializer
`timescale 1ns/1ps

module serdes_bypass_test;
    import serdes_bypass_pkg::*;
    localparam int F = 4;
    logic        sys_clk_in = 1'b0;
    logic        srst_in    = 1'b1;
    logic        psel_in    = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in  = 1'b0;
    logic [7:0]  paddr_in   = 8'h00;
    logic [31:0] pwdata_in  = 32'h0000_0000;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        inclk_en_in = 1'b0;
    logic [F-1:0] tx_data_in = '0;
    logic [F-1:0] rx_data_out;
    logic        rx_valid_out;
    logic        core_en_out;
    logic [0:0]  tx_hi_out;
    logic [0:0]  tx_lo_out;
    logic        tx_valid_out;
    logic        clk_hi_out;
    logic        clk_lo_out;
    logic [0:0]  rx_hi_in;
    logic [0:0]  rx_lo_in;
    phase_t      in_phase_out;
    phase_t      out_phase_out;
    logic        clk_bad;
    int          err_count       = 0;
    int          samples_checked = 0;
    logic [31:0] rd;
    logic [31:0] rd2;
    logic        er;
    logic [2:0]  ph_exp [8] = '{3'd0, 3'd4, 3'd1, 3'd3,
                                3'd4, 3'd5, 3'd6, 3'd7};
    logic [9:0]  rates  [6] = '{10'd623, 10'd624, 10'd231,
                                10'd232, 10'd421, 10'd420};
    logic [1:0]  modes  [6] = '{2'd0, 2'd0, 2'd0, 2'd0, 2'd0, 2'd1};
    logic [2:0]  flags  [6] = '{3'b110, 3'b111, 3'b000,
                                3'b010, 3'b110, 3'b000};

    always #25 sys_clk_in = ~sys_clk_in;

    always @(posedge sys_clk_in) begin
        inclk_en_in <= ($time % 200) < 50;
    end

    serdes_bypass #(.CHANNELS(1), .FACTOR(F), .MEM_AW(8)) uut (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in),
        .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .inclk_en_in(inclk_en_in), .tx_data_in(tx_data_in),
        .rx_data_out(rx_data_out), .rx_valid_out(rx_valid_out),
        .core_en_out(core_en_out), .tx_hi_out(tx_hi_out),
        .tx_lo_out(tx_lo_out), .tx_valid_out(tx_valid_out),
        .clk_hi_out(clk_hi_out), .clk_lo_out(clk_lo_out),
        .rx_hi_in(rx_hi_in), .rx_lo_in(rx_lo_in),
        .in_phase_out(in_phase_out), .out_phase_out(out_phase_out));

    lvds_remote_rx #(.CHANNELS(1)) far_end (
        .sys_clk_in(sys_clk_in), .srst_in(srst_in),
        .tx_hi_in(tx_hi_out), .tx_lo_in(tx_lo_out),
        .tx_valid_in(tx_valid_out), .clk_hi_in(clk_hi_out),
        .clk_lo_in(clk_lo_out), .rx_hi_out(rx_hi_in),
        .rx_lo_out(rx_lo_in), .clk_bad_out(clk_bad));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // ------------------------------------------------------------
    // APB master: setup, access until pready, one idle cycle
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel_in    <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in  <= wr;
        paddr_in   <= a;
        pwdata_in  <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        // Request held until the edge that samples pready high
        @(posedge sys_clk_in);
        while (pready_out !== 1'b1 && n < 50) begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= 50) err_count++;
        rd = prdata_out;
        er = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask : apb

    task automatic wait_hi(ref logic sig);
        int n;
        n = 0;
        while (sig !== 1'b1 && n < 300) begin
            @(posedge sys_clk_in);
            n++;
        end
        check(32'(sig), 32'd1);
    endtask : wait_hi

    task automatic test_done();
        $display("compares=%0d mismatches=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    initial begin
        #400_000;
        err_count++;
        test_done();
    end

    initial begin
        repeat (8) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        @(posedge sys_clk_in);
        // Reset state and register defaults
        check({clk_hi_out, clk_lo_out}, 2'b10);
        apb(1'b0, 8'h00, 0); check(rd, 32'h0000_0004);
        apb(1'b0, 8'h04, 0); check(rd, 32'h0000_0000);
        apb(1'b0, 8'h08, 0); check(rd, 32'h0200_0000);
        apb(1'b1, 8'h08, 32'hFFFF_FFFF);
        apb(1'b0, 8'h08, 0); check(rd, 32'h0200_0000);
        apb(1'b1, 8'h0C, 32'h1234_5678); check(er, 1'b1);
        apb(1'b0, 8'h0C, 0); check(er, 1'b1);
        check(rd, 32'h0000_0000);
        $display("test registers done");
        // Every alignment code, center equal to 180
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, 8'h00, (k << 5) | (k << 8) | 4);
            // Phase output lags the alignment field by one cycle
            @(posedge sys_clk_in);
            check(in_phase_out, ph_exp[k]);
            check(out_phase_out, ph_exp[k]);
        end
        $display("test alignment done");
        // Rate limits per mode
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, 8'h00, 32'(modes[k]) << 1);
            apb(1'b1, 8'h04, 32'(rates[k]));
            apb(1'b0, 8'h08, 0);
            check(rd[6:4], flags[k]);
        end
        $display("test rate flags done");
        // Two bits per clock through the DDR slots, MSB in high slot
        apb(1'b1, 8'h00, 32'h0000_0003);
        tx_data_in <= 4'b0110;
        repeat (4) @(posedge sys_clk_in);
        check({tx_hi_out, tx_lo_out}, 2'b10);
        tx_data_in <= 4'b0001;
        repeat (4) @(posedge sys_clk_in);
        check({tx_hi_out, tx_lo_out}, 2'b01);
        apb(1'b1, 8'h00, 32'h0000_0001);
        repeat (4) @(posedge sys_clk_in);
        check({tx_hi_out, tx_lo_out}, 2'b11);
        // Input register on the reference enable, x2 path
        apb(1'b1, 8'h00, 32'h0000_000B);
        tx_data_in <= 4'b0110;
        repeat (8) @(posedge sys_clk_in);
        check({tx_hi_out, tx_lo_out}, 2'b10);
        tx_data_in <= 4'b0001;
        repeat (8) @(posedge sys_clk_in);
        check({tx_hi_out, tx_lo_out}, 2'b01);
        $display("test ddr slots done");
        // Gearbox loop through the far end
        tx_data_in <= 4'hA;
        apb(1'b1, 8'h00, 32'h0000_0005);
        wait_hi(tx_valid_out);
        wait_hi(rx_valid_out);
        repeat (6 * F) @(posedge sys_clk_in);
        check(rx_data_out, 4'hA);
        apb(1'b0, 8'h08, 0);
        rd2 = rd;
        apb(1'b0, 8'h08, 0);
        check(rd[3:0], 4'hF);
        check(rd[23:20], 4'h0);
        check(4'(rd[19:16] - rd2[19:16]), 4'd3);
        check(clk_bad, 1'b0);
        $display("test gearbox done");
        test_done();
    end
endmodule : serdes_bypass_test
